// ===== design/pmtr_top.v
`timescale 1ns/1ps
`include "pmtr_consts.vh"

// Summary of operation
// RL1: The program store holds 2K words of 16 bits for code, tables and vectors.
// RL2: After reset the program counter is 000H and fetching starts there.
// RL3: A table may sit at any address of the program store.
// RL4: The table address is the high pointer bits joined above the low pointer.
// RL5: A table read writes the low byte of the word to the operand's data register.
// RL6: The same table read puts the high byte into the table result high register.
// RL7: The table result high register cannot be written by software.
// RL8: Every table instruction takes two instruction cycles.
// RL9: Software should mask interrupts around main-routine table reads.
// RL10: The programming link moves data both ways on one line timed by the writer's clock.
// RL11: Programming data shares port A bit 0 and programming clock shares port A bit 2.
// RL12: Nothing else may drive the two shared pins while programming runs.
// RL13: The debug link uses one two-way data pin and one clock input from the adapter.
// RL14: In emulation the other functions on the debug pins are off, pins still program.
// RL15: In the extra table cycle the store is addressed by the pointer, then fetch resumes.
// RL16: The program counter is 11 bits and only its low byte is visible to software.
module pmtr_top #(
    parameter ADDR_W = `PMTR_ADDR_W,
    parameter DATA_W = `PMTR_DATA_W
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Core control
    input wire i_jump,
    input wire [ADDR_W-1:0] i_jump_addr,
    input wire i_pcl_wr,
    input wire [7:0] i_pcl_wdata,
    input wire i_tblp_wr,
    input wire i_tbhp_wr,
    input wire [7:0] i_ptr_wdata,
    input wire i_tabrd,
    input wire [7:0] i_tabrd_dest,
    input wire i_prog_mode,
    input wire i_debug_mode,
    // Instruction fetch
    output reg [DATA_W-1:0] o_instr,
    output reg o_instr_valid,
    output reg [ADDR_W-1:0] o_fetch_addr,
    output reg o_busy,
    // Software-visible state
    output wire [7:0] o_program_counter_low,
    output wire [7:0] o_tblp,
    output wire [7:0] o_tbhp,
    output reg [7:0] o_table_result_high,
    // Data memory write of the table low byte
    output reg o_dm_wr,
    output reg [7:0] o_dm_addr,
    output reg [7:0] o_dm_wdata,
    // General purpose port functions of the shared pins
    input wire i_gpio_a0_out,
    input wire i_gpio_a0_oe_n,
    input wire i_gpio_a2_out,
    input wire i_gpio_a2_oe_n,
    output reg o_gpio_a0_in,
    output reg o_gpio_a2_in,
    // Shared pins: port_a_bit0 carries serial data, port_a_bit2 serial clock
    input wire i_port_a_bit0,
    output reg o_port_a_bit0,
    output reg o_port_a_bit0_oe_n,
    input wire i_port_a_bit2,
    output reg o_port_a_bit2,
    output reg o_port_a_bit2_oe_n
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg [ADDR_W-1:0] pc_q;
    reg [ADDR_W-1:0] pc_d;
    reg [7:0] tblp_q;
    reg [7:0] tbhp_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] dest_q;
    reg fetch_q;
    reg [ADDR_W-1:0] fetch_addr_q;
    reg [ADDR_W-1:0] mem_raddr;
    wire [DATA_W-1:0] mem_rdata;
    wire [ADDR_W-1:0] table_addr;
    wire fetch_now;
    wire link_active;

    reg [1:0] sda_sync_q;
    reg [2:0] sck_sync_q;
    wire sda_in;
    wire sck_rise;
    wire sck_fall;

    reg [`PMTR_CNT_W-1:0] cnt_q;
    reg [`PMTR_HDR_W-1:0] hdr_q;
    reg [DATA_W-1:0] dat_q;
    reg rd_q;
    reg load_q;
    reg we_q;
    reg [DATA_W-1:0] wdata_q;
    reg sdo_q;
    reg drive_q;
    wire hdr_done;
    wire cmd_is_write;
    wire last_bit;

    // ------------------------------------------------------------------------
    // Program store
    // ------------------------------------------------------------------------
    // RL1 2K x 16 store
    pmtr_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_mem (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_we(we_q),
        .i_waddr(hdr_q[ADDR_W-1:0]),
        .i_wdata(wdata_q),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    // RL14 link owns the shared pins in either mode
    assign link_active = i_prog_mode | i_debug_mode;
    assign fetch_now = (state_q == `PMTR_ST_IDLE) & ~link_active;

    // RL4 pointer pair forms the table address
    // RL3 any word is reachable
    assign table_addr = {tbhp_q[ADDR_W-9:0], tblp_q};

    // RL15 pointer drives the store in the extra cycle
    always @* begin
        if (rd_q) begin
            mem_raddr = hdr_q[ADDR_W-1:0];
        end else if (state_q == `PMTR_ST_TAB_ADDR) begin
            mem_raddr = table_addr;
        end else begin
            mem_raddr = pc_q;
        end
    end

    // ------------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------------
    // RL16 only the low byte is software visible
    assign o_program_counter_low = pc_q[7:0];

    // A full jump wins over a low-byte write, which can only move within the
    // current 256-word page because the upper bits are not reachable.
    always @* begin
        pc_d = pc_q;
        if (i_jump) begin
            pc_d = i_jump_addr;
        end else if (i_pcl_wr) begin
            pc_d = {pc_q[ADDR_W-1:8], i_pcl_wdata};
        end else if (fetch_now) begin
            pc_d = pc_q + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
    end

    // RL2 reset vector
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_q <= `PMTR_RESET_VECTOR;
            fetch_q <= 1'b0;
            fetch_addr_q <= `PMTR_RESET_VECTOR;
            o_instr <= {DATA_W{1'b0}};
            o_instr_valid <= 1'b0;
            o_fetch_addr <= `PMTR_RESET_VECTOR;
        end else begin
            pc_q <= pc_d;
            fetch_q <= fetch_now;
            fetch_addr_q <= pc_q;
            o_instr <= mem_rdata;
            o_instr_valid <= fetch_q;
            o_fetch_addr <= fetch_addr_q;
        end
    end

    // ------------------------------------------------------------------------
    // Table pointers and table read sequencer
    // ------------------------------------------------------------------------
    assign o_tblp = tblp_q;
    assign o_tbhp = tbhp_q;

    always @* begin
        state_d = state_q;
        case (state_q)
            `PMTR_ST_IDLE: begin
                if (i_tabrd && !link_active) begin
                    state_d = `PMTR_ST_TAB_ADDR;
                end
            end
            `PMTR_ST_TAB_ADDR: begin
                state_d = `PMTR_ST_TAB_DATA;
            end
            `PMTR_ST_TAB_DATA: begin
                state_d = `PMTR_ST_IDLE;
            end
            default: begin
                state_d = `PMTR_ST_IDLE;
            end
        endcase
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tblp_q <= 8'h00;
            tbhp_q <= 8'h00;
            state_q <= `PMTR_ST_IDLE;
            dest_q <= 8'h00;
            o_busy <= 1'b0;
            o_dm_wr <= 1'b0;
            o_dm_addr <= 8'h00;
            o_dm_wdata <= 8'h00;
            o_table_result_high <= 8'h00;
        end else begin
            state_q <= state_d;
            o_dm_wr <= 1'b0;
            if (i_tblp_wr) begin
                tblp_q <= i_ptr_wdata;
            end
            if (i_tbhp_wr) begin
                tbhp_q <= i_ptr_wdata;
            end
            // RL8 busy spans the two table cycles
            if (state_d != `PMTR_ST_IDLE) begin
                o_busy <= 1'b1;
            end else begin
                o_busy <= 1'b0;
            end
            if (state_q == `PMTR_ST_IDLE && state_d == `PMTR_ST_TAB_ADDR) begin
                dest_q <= i_tabrd_dest;
            end
            if (state_q == `PMTR_ST_TAB_DATA) begin
                // RL5 low byte to operand register
                o_dm_wr <= 1'b1;
                o_dm_addr <= dest_q;
                o_dm_wdata <= mem_rdata[`PMTR_BYTE_W-1:0];
                // RL6 high byte to result register
                // RL7 only a table read loads it
                o_table_result_high <= mem_rdata[DATA_W-1:`PMTR_BYTE_W];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers and serial clock edge detection
    // ------------------------------------------------------------------------
    // The third stage only serves the edge detector; the first stage is
    // read by nothing but the second.
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sda_sync_q <= 2'h0;
            sck_sync_q <= 3'h0;
        end else begin
            sda_sync_q <= {sda_sync_q[0], i_port_a_bit0};
            sck_sync_q <= {sck_sync_q[1:0], i_port_a_bit2};
        end
    end

    assign sda_in = sda_sync_q[1];
    assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
    assign sck_fall = ~sck_sync_q[1] & sck_sync_q[2];

    // ------------------------------------------------------------------------
    // Serial programming and debug link
    // ------------------------------------------------------------------------
    // RL10 one data line, clocked by the far end
    // RL13 same engine serves the debug adapter
    assign hdr_done = (cnt_q >= `PMTR_HDR_BITS);
    assign cmd_is_write = (hdr_q[`PMTR_HDR_W-1] == `PMTR_CMD_WRITE);
    assign last_bit = (cnt_q == (`PMTR_FRAME_BITS - 5'h01));

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 5'h00;
            hdr_q <= 12'h000;
            dat_q <= {DATA_W{1'b0}};
            rd_q <= 1'b0;
            load_q <= 1'b0;
            we_q <= 1'b0;
            wdata_q <= {DATA_W{1'b0}};
            sdo_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            rd_q <= 1'b0;
            we_q <= 1'b0;
            load_q <= rd_q;
            if (!link_active) begin
                cnt_q <= 5'h00;
                drive_q <= 1'b0;
            end else begin
                if (sck_rise) begin
                    if (!hdr_done) begin
                        hdr_q <= {hdr_q[`PMTR_HDR_W-2:0], sda_in};
                    end else if (cmd_is_write) begin
                        dat_q <= {dat_q[DATA_W-2:0], sda_in};
                    end
                    if (last_bit) begin
                        cnt_q <= 5'h00;
                        drive_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                    if (cnt_q == (`PMTR_HDR_BITS - 5'h01) &&
                        hdr_q[`PMTR_HDR_W-2] == `PMTR_CMD_READ) begin
                        rd_q <= 1'b1;
                        drive_q <= 1'b1;
                    end
                    if (last_bit && cmd_is_write) begin
                        we_q <= 1'b1;
                        wdata_q <= {dat_q[DATA_W-2:0], sda_in};
                    end
                end
                // Loading wins over shifting; a falling edge cannot come this
                // soon after the header's last rising edge at any legal rate.
                if (load_q) begin
                    dat_q <= mem_rdata;
                end else if (sck_fall && hdr_done && !cmd_is_write) begin
                    sdo_q <= dat_q[DATA_W-1];
                    dat_q <= {dat_q[DATA_W-2:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Shared pin multiplexing
    // ------------------------------------------------------------------------
    // RL11 data on port_a_bit0, clock on port_a_bit2
    // RL14 port functions are cut off while the link owns the pins
    // RL12 clock pin is never driven by the device in link mode
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_port_a_bit0 <= 1'b0;
            o_port_a_bit0_oe_n <= 1'b1;
            o_port_a_bit2 <= 1'b0;
            o_port_a_bit2_oe_n <= 1'b1;
            o_gpio_a0_in <= 1'b0;
            o_gpio_a2_in <= 1'b0;
        end else if (link_active) begin
            o_port_a_bit0 <= sdo_q;
            o_port_a_bit0_oe_n <= ~drive_q;
            o_port_a_bit2 <= 1'b0;
            o_port_a_bit2_oe_n <= 1'b1;
            o_gpio_a0_in <= 1'b0;
            o_gpio_a2_in <= 1'b0;
        end else begin
            o_port_a_bit0 <= i_gpio_a0_out;
            o_port_a_bit0_oe_n <= i_gpio_a0_oe_n;
            o_port_a_bit2 <= i_gpio_a2_out;
            o_port_a_bit2_oe_n <= i_gpio_a2_oe_n;
            o_gpio_a0_in <= sda_in;
            o_gpio_a2_in <= sck_sync_q[1];
        end
    end

endmodule

// ===== design/pmtr_consts.vh
`ifndef PMTR_CONSTS_VH
`define PMTR_CONSTS_VH

// ----------------------------------------------------------------------------
// Program store geometry
// ----------------------------------------------------------------------------
`define PMTR_ADDR_W 11
`define PMTR_DATA_W 16
`define PMTR_BYTE_W 8
`define PMTR_RESET_VECTOR 11'h000

// ----------------------------------------------------------------------------
// Table read sequencer states
// ----------------------------------------------------------------------------
`define PMTR_ST_IDLE 2'h0
`define PMTR_ST_TAB_ADDR 2'h1
`define PMTR_ST_TAB_DATA 2'h2

// ----------------------------------------------------------------------------
// Serial link frame: one command bit, eleven address bits, sixteen data bits
// ----------------------------------------------------------------------------
`define PMTR_CNT_W 5
`define PMTR_HDR_W 12
`define PMTR_HDR_BITS 5'h0c
`define PMTR_FRAME_BITS 5'h1c
`define PMTR_CMD_WRITE 1'b1
`define PMTR_CMD_READ 1'b0

`endif

// ===== design/pmtr_mem.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Program store: one write port, one read port with registered data
// ----------------------------------------------------------------------------
module pmtr_mem #(
    parameter ADDR_W = 11,
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Write port
    input wire i_we,
    input wire [ADDR_W-1:0] i_waddr,
    input wire [DATA_W-1:0] i_wdata,
    // Read port
    input wire [ADDR_W-1:0] i_raddr,
    output reg [DATA_W-1:0] o_rdata
);

    reg [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= {DATA_W{1'b0}};
        end else begin
            o_rdata <= mem_q[i_raddr];
        end
    end

endmodule

// ===== verif/pmtr_props.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Port-level checks of fetch, table read and pin sharing
// ----------------------------------------------------------------------------
module pmtr_props #(
    parameter ADDR_W = 11,
    parameter DATA_W = 16
) (
    input wire logic i_core_clk, input wire logic i_rst_n,
    input wire logic i_jump, input wire logic [ADDR_W-1:0] i_jump_addr,
    input wire logic i_pcl_wr, input wire logic [7:0] i_pcl_wdata,
    input wire logic i_tabrd, input wire logic [7:0] i_tabrd_dest,
    input wire logic i_prog_mode, input wire logic i_debug_mode,
    input wire logic i_gpio_a0_out, input wire logic i_gpio_a0_oe_n,
    input wire logic o_instr_valid, input wire logic [ADDR_W-1:0] o_fetch_addr,
    input wire logic o_busy, input wire logic [7:0] o_program_counter_low,
    input wire logic [7:0] o_table_result_high, input wire logic o_dm_wr,
    input wire logic [7:0] o_dm_addr, input wire logic o_gpio_a0_in,
    input wire logic o_gpio_a2_in, input wire logic o_port_a_bit0,
    input wire logic o_port_a_bit0_oe_n, input wire logic o_port_a_bit2_oe_n
);
    wire link = i_prog_mode | i_debug_mode;
    wire [7:0] jump_lo = i_jump_addr[7:0];

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_take;
        i_tabrd && !o_busy && !link;
    endsequence
    sequence s_link3;
        link [*3];
    endsequence

    property p_reset_vector;
        $rose(i_rst_n) && !link && !i_jump && !i_pcl_wr && !i_tabrd
            |-> ##[1:3] (o_instr_valid && o_fetch_addr == 11'h000);
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("no fetch of 000 after reset");
    property p_tab_seq;
        s_take |-> ##1 o_busy [*2] ##1 (o_dm_wr && !o_busy && o_dm_addr == $past(i_tabrd_dest, 3));
    endproperty
    a_tab_seq: assert property (p_tab_seq) else $error("table read timing or destination wrong");
    property p_busy_len;
        $rose(o_busy) |=> o_busy ##1 !o_busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy not exactly two cycles");
    property p_dm_pulse;
        o_dm_wr |=> !o_dm_wr;
    endproperty
    a_dm_pulse: assert property (p_dm_pulse) else $error("data write longer than one cycle");
    property p_table_result_high_ro;
        !$stable(o_table_result_high) |-> o_dm_wr;
    endproperty
    a_table_result_high_ro: assert property (p_table_result_high_ro) else $error("high byte changed outside a table read");
    property p_link_quiet;
        link [*4] |-> !o_instr_valid;
    endproperty
    a_link_quiet: assert property (p_link_quiet) else $error("fetch while link mode");
    property p_link_pins;
        s_link3 |-> !o_gpio_a0_in && !o_gpio_a2_in && o_port_a_bit2_oe_n;
    endproperty
    a_link_pins: assert property (p_link_pins) else $error("shared pin function active in link mode");
    property p_pin_mux;
        !link && !$past(i_prog_mode) && !$past(i_debug_mode) && $past(i_rst_n)
            |-> o_port_a_bit0_oe_n == $past(i_gpio_a0_oe_n) && o_port_a_bit0 == $past(i_gpio_a0_out);
    endproperty
    a_pin_mux: assert property (p_pin_mux) else $error("port bit 0 not following port logic");
    property p_jump_pc;
        i_jump && !o_busy && !link |=> o_program_counter_low == $past(jump_lo);
    endproperty
    a_jump_pc: assert property (p_jump_pc) else $error("jump not loaded into counter");
    property p_pcl_wr;
        i_pcl_wr && !i_jump && !o_busy && !link |=> o_program_counter_low == $past(i_pcl_wdata);
    endproperty
    a_pcl_wr: assert property (p_pcl_wr) else $error("low byte write not loaded");
endmodule

bind pmtr_top pmtr_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) pmtr_props_inst (.*);

// ===== verif/pmtr_link_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Serial writer on the shared pins; clock idles low between frames
// ----------------------------------------------------------------------------
module pmtr_link_model (
    input wire logic i_line,
    output logic o_clk,
    output logic o_data
);
    initial begin
        o_clk = 1'b0;
        o_data = 1'b0;
    end

    task automatic put_bit(input logic b);
        o_data = b;
        #100 o_clk = 1'b1;
        #100 o_clk = 1'b0;
    endtask

    task automatic header(input logic cmd, input logic [10:0] a);
        #17;
        put_bit(cmd);
        for (int i = 10; i >= 0; i--) put_bit(a[i]);
    endtask

    task automatic write_word(input logic [10:0] a, input logic [15:0] d);
        header(1'b1, a);
        for (int i = 15; i >= 0; i--) put_bit(d[i]);
        #400;
    endtask

    task automatic read_word(input logic [10:0] a, output logic [15:0] d);
        header(1'b0, a);
        o_data = ~o_data;
        for (int i = 15; i >= 0; i--) begin
            #100 o_clk = 1'b1;
            d[i] = i_line;
            #100 o_clk = 1'b0;
            o_data = ~o_data;
        end
        #400;
    endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_jump = 1'b0, i_pcl_wr = 1'b0;
    logic i_tblp_wr = 1'b0, i_tbhp_wr = 1'b0, i_tabrd = 1'b0;
    logic i_prog_mode = 1'b0, i_debug_mode = 1'b0;
    logic [10:0] i_jump_addr = 11'h000;
    logic [7:0] i_pcl_wdata = 8'h00, i_ptr_wdata = 8'h00, i_tabrd_dest = 8'h00;
    logic i_gpio_a0_out = 1'b1, i_gpio_a0_oe_n = 1'b0, i_gpio_a2_out = 1'b0, i_gpio_a2_oe_n = 1'b0;
    wire [15:0] o_instr;
    wire [10:0] o_fetch_addr;
    wire [7:0] o_program_counter_low, o_tblp, o_tbhp, o_table_result_high, o_dm_addr, o_dm_wdata;
    wire o_instr_valid, o_busy, o_dm_wr, o_gpio_a0_in, o_gpio_a2_in;
    wire o_port_a_bit0, o_port_a_bit0_oe_n, o_port_a_bit2, o_port_a_bit2_oe_n;
    wire link_clk, link_data, pin0, pin2;
    int failures = 0;
    int n_tests = 0;
    logic [15:0] exp_mem [0:2047];
    logic [10:0] addr_l [0:7] = '{11'h000, 11'h001, 11'h002, 11'h004, 11'h706, 11'h7ff, 11'h734, 11'h735};
    logic [15:0] data_l [0:7] = '{16'ha5c3, 16'h1234, 16'hbeef, 16'h0f0f, 16'h0f1a, 16'hc35a,
                                  16'h7e81, 16'h0042};

    // Each shared pin carries whichever party has its driver enabled.
    assign pin0 = o_port_a_bit0_oe_n ? link_data : o_port_a_bit0;
    assign pin2 = o_port_a_bit2_oe_n ? link_clk : o_port_a_bit2;

    pmtr_top pmtr_top_inst (
        .i_core_clk, .i_rst_n, .i_jump, .i_jump_addr, .i_pcl_wr, .i_pcl_wdata, .i_tblp_wr,
        .i_tbhp_wr, .i_ptr_wdata, .i_tabrd, .i_tabrd_dest, .i_prog_mode, .i_debug_mode,
        .o_instr, .o_instr_valid, .o_fetch_addr, .o_busy, .o_program_counter_low, .o_tblp,
        .o_tbhp, .o_table_result_high, .o_dm_wr, .o_dm_addr, .o_dm_wdata, .i_gpio_a0_out,
        .i_gpio_a0_oe_n, .i_gpio_a2_out, .i_gpio_a2_oe_n, .o_gpio_a0_in, .o_gpio_a2_in,
        .i_port_a_bit0(pin0), .o_port_a_bit0, .o_port_a_bit0_oe_n, .i_port_a_bit2(pin2),
        .o_port_a_bit2, .o_port_a_bit2_oe_n
    );

    pmtr_link_model pmtr_link_model_inst (.i_line(pin0), .o_clk(link_clk), .o_data(link_data));

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic set_mode(input logic p, input logic d);
        @(negedge i_core_clk);
        i_prog_mode = p;
        i_debug_mode = d;
        repeat (6) @(negedge i_core_clk);
    endtask

    task automatic expect_fetch(input logic [10:0] a);
        int k;
        for (k = 0; k < 8 && !(o_instr_valid === 1'b1 && o_fetch_addr === a); k++)
            @(negedge i_core_clk);
        if (k == 8) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, o_fetch_addr, a);
            finish_test();
        end
        chk(o_instr, exp_mem[a]);
        @(negedge i_core_clk);
    endtask

    task automatic set_ptr(input logic [7:0] lo, input logic [7:0] hi);
        @(negedge i_core_clk);
        i_tblp_wr = 1'b1;
        i_ptr_wdata = lo;
        @(negedge i_core_clk);
        i_tblp_wr = 1'b0;
        i_tbhp_wr = 1'b1;
        i_ptr_wdata = hi;
        @(negedge i_core_clk);
        i_tbhp_wr = 1'b0;
        chk(16'({o_tbhp, o_tblp}), 16'({hi, lo}));
    endtask

    task automatic tab_read(input logic [7:0] dest, input logic [10:0] a, input bit chained);
        if (!chained) @(negedge i_core_clk);
        i_tabrd = 1'b1;
        i_tabrd_dest = dest;
        @(negedge i_core_clk);
        i_tabrd = 1'b0;
        chk(16'(o_busy), 16'h0001);
        @(negedge i_core_clk);
        chk(16'(o_busy), 16'h0001);
        @(negedge i_core_clk);
        chk(16'({o_busy, o_dm_wr}), 16'h0001);
        chk(16'(o_dm_addr), 16'(dest));
        chk(16'(o_dm_wdata), 16'(exp_mem[a][7:0]));
        chk(16'(o_table_result_high), 16'(exp_mem[a][15:8]));
    endtask

    task automatic t_link;
        logic [15:0] r;
        set_mode(1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            pmtr_link_model_inst.write_word(addr_l[i], data_l[i]);
            exp_mem[addr_l[i]] = data_l[i];
        end
        pmtr_link_model_inst.read_word(11'h706, r);
        chk(r, exp_mem[11'h706]);
        pmtr_link_model_inst.read_word(11'h7ff, r);
        chk(r, exp_mem[11'h7ff]);
        set_mode(1'b0, 1'b1);
        pmtr_link_model_inst.write_word(11'h003, 16'h5aa5);
        exp_mem[11'h003] = 16'h5aa5;
        pmtr_link_model_inst.read_word(11'h003, r);
        chk(r, 16'h5aa5);
        set_mode(1'b0, 1'b0);
    endtask

    task automatic t_reset;
        @(negedge i_core_clk);
        i_rst_n = 1'b0;
        repeat (6) @(negedge i_core_clk);
        chk(16'({o_busy, o_program_counter_low}), 16'h0000);
        i_rst_n = 1'b1;
        for (int i = 0; i < 5; i++) expect_fetch(11'(i));
    endtask

    task automatic t_table;
        logic [7:0] hi;
        set_ptr(8'hff, 8'hf7);
        tab_read(8'h5a, 11'h7ff, 1'b0);
        tab_read(8'ha6, 11'h7ff, 1'b1);
        hi = o_table_result_high;
        set_ptr(8'h06, 8'h07);
        chk(16'(o_table_result_high), 16'(hi));
        tab_read(8'h11, 11'h706, 1'b0);
        set_ptr(8'h00, 8'h00);
        @(negedge i_core_clk);
        i_jump = 1'b1;
        i_jump_addr = 11'h001;
        @(negedge i_core_clk);
        i_jump = 1'b0;
        tab_read(8'h22, 11'h000, 1'b1);
        expect_fetch(11'h002);
    endtask

    task automatic t_pins;
        @(negedge i_core_clk);
        i_gpio_a2_out = 1'b1;
        @(negedge i_core_clk);
        chk(16'(o_port_a_bit2), 16'h0001);
        repeat (3) @(negedge i_core_clk);
        chk(16'({o_gpio_a2_in, o_gpio_a0_in}), 16'h0003);
        i_gpio_a2_out = 1'b0;
    endtask

    task automatic t_pcl;
        @(negedge i_core_clk);
        i_jump = 1'b1;
        i_jump_addr = 11'h700;
        @(negedge i_core_clk);
        i_jump = 1'b0;
        i_pcl_wr = 1'b1;
        i_pcl_wdata = 8'h34;
        @(negedge i_core_clk);
        i_pcl_wr = 1'b0;
        chk(16'(o_program_counter_low), 16'h0034);
        expect_fetch(11'h734);
        expect_fetch(11'h735);
    endtask

    initial begin
        repeat (6) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        t_link();
        t_reset();
        t_table();
        t_pcl();
        t_pins();
        finish_test();
    end
endmodule
